// ### logic/fhrb_pkg.sv
package fhrb_pkg;
   // Register word offsets (each register on one aligned 32-bit word)
   localparam logic [3:0] OFS_PIN_MON_B = 4'h1;
   localparam logic [3:0] OFS_DRIVE_OUT = 4'h2;
   localparam logic [3:0] OFS_TAPE_MEDIA = 4'h3;
   localparam logic [3:0] OFS_RATE_STAT = 4'h4;
   localparam logic [3:0] OFS_FIFO = 4'h5;
   localparam logic [3:0] OFS_MEDIA_CC = 4'h7;
   localparam logic [3:0] OFS_STATUS_ZERO = 4'h8;
   localparam logic [3:0] OFS_CFG = 4'h9;
   localparam logic [3:0] OFS_CFG2 = 4'hA;
   localparam logic [3:0] OFS_EVENT = 4'hB;

   // Register layout variants
   localparam logic [1:0] LAYOUT_AT = 2'h0;
   localparam logic [1:0] LAYOUT_PRIMARY = 2'h1;
   localparam logic [1:0] LAYOUT_REDUCED = 2'h2;

   // Rate select encodings
   localparam logic [1:0] RATE_500K = 2'h0;
   localparam logic [1:0] RATE_300K = 2'h1;
   localparam logic [1:0] RATE_250K = 2'h2;
   localparam logic [1:0] RATE_1M = 2'h3;
   localparam logic [1:0] RATE_TABLE_2M = 2'h2;

   // Precompensation codes and delays in 10 ps units
   localparam logic [2:0] PRECOMP_DEFAULT = 3'h0;
   localparam logic [2:0] PRECOMP_OFF = 3'h7;
   localparam logic [15:0] PRECOMP_STEP = 16'h1047;
   localparam logic [15:0] PRECOMP_STEP_2M = 16'h0820;
   localparam logic [15:0] PRECOMP_DEF_LOW = 16'h30D4;

   // Termination codes
   localparam logic [1:0] TERM_NORMAL = 2'h0;
   localparam logic [1:0] TERM_ABNORMAL = 2'h1;
   localparam logic [1:0] TERM_INVALID = 2'h2;
   localparam logic [6:0] TRACK0_STEP_LIMIT = 7'h4D;

   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [7:0] FLOAT_READ = 8'h7F;
   localparam int FIFO_DEPTH = 4;

   typedef struct packed {
      logic write_data_out;
      logic read_data_in;
      logic write_gate_n;
      logic motor_a_enable_n;
      logic drive_a_select_pin;
      logic disk_change_input;
   } fhrb_pins_t;

   typedef struct packed {
      logic [1:0] termination_code;
      logic seek_end_flag;
      logic equipment_fault;
      logic not_ready_flag;
      logic head_address;
      logic [1:0] unit_select;
   } fhrb_st0_t;
endpackage

// ### logic/fhrb_top.sv
// Function
// - Monitor bit 5 mirrors drive select bit 0
// - Bits 4,3 toggle on write/read data rises
// - Bits 2,0 invert write gate and motor A
// - Reduced layout: select pin, latched inverted flops
// - Write-only drive output register at offset two
// - Three-mode: media and boot bits copied in
// - Drive type bits follow last selected drive
// - Tape bits give tape logical drive number
// - Last written rate register sets effective rate
// - Rate bit 7 resets, bit 6 powers down
// - Precomp code picks delay, default, or off
// - Rate code sets speed and reduced current
// - Tape 2M needs code 01, table 10
// - Four-deep data FIFO, disabled until configured
// - Status zero bits 7:6 termination code
// - Status zero seek, fault, ready, head, drive
// - AT layout: bit 7 inverted change, rest float
// - Primary: inverted change, ones, rate bits
// - Primary bit 0 low for high density
// - Reduced: true change, DMA, precomp-off, rate
// - Reduced config bit 2 disables precompensation
`timescale 1ns/100ps
module fhrb_top #(
   parameter int DEPTH = fhrb_pkg::FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [1:0] layout_select,
   input wire fhrb_pkg::fhrb_pins_t pins_in,
   input wire fhrb_pkg::fhrb_st0_t status_zero_in,
   input wire logic status_zero_load,
   output logic [1:0] rate_select,
   output logic reduced_write_current,
   output logic [2:0] precomp_select,
   output logic [15:0] precomp_delay,
   output logic tape_2m_rate,
   output logic power_down,
   output logic controller_reset,
   output logic [3:0] motor_enable,
   output logic [1:0] drive_select,
   output logic dma_request_enable
);
   typedef struct packed {
      logic [31:0] rdata;
      logic ack;
      logic [7:0] dout;
      logic [1:0] tape_sel;
      logic [7:0] rate_reg;
      logic [2:0] cc_reg;
      logic [1:0] rate_eff;
      logic sw_reset;
      logic fifo_en;
      logic [DEPTH-1:0][7:0] fifo;
      logic [2:0] fifo_cnt;
      logic [7:0] st0;
      logic [7:0] cfg;
      logic [7:0] cfg2;
      logic three_mode_enable;
      logic [5:0] s1, s2, s3;
      logic wd_tog, rd_tog;
      logic wd_ff, rd_ff, wg_ff;
      logic [15:0] pdelay;
   } fhrb_state_t;

   fhrb_state_t q, d;
   fhrb_pkg::fhrb_pins_t p_now, p_old;

   function automatic logic [15:0] precomp_ps(input logic [2:0] code,
      input logic [1:0] rate, input logic tape2m, input logic precomp_disable);
      logic [15:0] step;
      step = tape2m ? fhrb_pkg::PRECOMP_STEP_2M : fhrb_pkg::PRECOMP_STEP;
      if (precomp_disable || code == fhrb_pkg::PRECOMP_OFF) begin
         precomp_ps = 16'h0000;
      end else if (code == fhrb_pkg::PRECOMP_DEFAULT) begin
         if (tape2m) begin
            precomp_ps = fhrb_pkg::PRECOMP_STEP_2M;
         end else if (rate == fhrb_pkg::RATE_1M) begin
            precomp_ps = fhrb_pkg::PRECOMP_STEP;
         end else begin
            precomp_ps = fhrb_pkg::PRECOMP_DEF_LOW;
         end
      end else begin
         precomp_ps = 16'(step * code);
      end
   endfunction

   // Tape 2M needs both the 300K code and the 2M rate table
   function automatic logic tape_rate_2m(input logic [1:0] rate,
      input logic [1:0] table_sel);
      tape_rate_2m = rate == fhrb_pkg::RATE_300K &&
                     table_sel == fhrb_pkg::RATE_TABLE_2M;
   endfunction

   // Pins pass three flops; a rise counts when stage two is high and stage three is low
   assign p_now = q.s2;
   assign p_old = q.s3;

   always_comb begin
      logic wd_rise, rd_rise, tape2m, hit_w, hit_r;
      logic [7:0] wb, rb;
      logic [1:0] sel;
      d = q;
      wb = avs_writedata[7:0];
      rb = fhrb_pkg::RESET_ZERO;
      sel = q.dout[1:0];
      d.s1 = pins_in;
      d.s2 = q.s1;
      d.s3 = q.s2;
      wd_rise = p_now.write_data_out && !p_old.write_data_out;
      rd_rise = p_now.read_data_in && !p_old.read_data_in;
      if (wd_rise) begin
         d.wd_tog = !q.wd_tog;
         d.wd_ff = !p_now.write_data_out;
         d.wg_ff = !p_now.write_gate_n;
      end
      if (rd_rise) begin
         d.rd_tog = !q.rd_tog;
         d.rd_ff = !p_now.read_data_in;
      end
      d.ack = 1'b0;
      d.sw_reset = 1'b0;
      hit_w = avs_write && !q.ack;
      hit_r = avs_read && !q.ack;
      if (avs_read || avs_write) begin
         d.ack = !q.ack;
      end
      if (status_zero_load) begin
         d.st0 = status_zero_in;
      end
      if (hit_w) begin
         if (avs_address == fhrb_pkg::OFS_DRIVE_OUT) begin
            d.dout = wb;
         end else if (avs_address == fhrb_pkg::OFS_TAPE_MEDIA) begin
            d.tape_sel = wb[1:0];
         end else if (avs_address == fhrb_pkg::OFS_RATE_STAT) begin
            d.rate_reg = wb;
            d.rate_eff = wb[1:0];
            d.sw_reset = wb[7];
         end else if (avs_address == fhrb_pkg::OFS_FIFO) begin
            if (q.fifo_en && q.fifo_cnt < 3'(DEPTH)) begin
               d.fifo[q.fifo_cnt[1:0]] = wb;
               d.fifo_cnt = q.fifo_cnt + 3'h1;
            end
         end else if (avs_address == fhrb_pkg::OFS_MEDIA_CC) begin
            // Reserved bits are dropped; software is expected to send 0
            d.cc_reg = wb[2:0];
            d.rate_eff = wb[1:0];
         end else if (avs_address == fhrb_pkg::OFS_CFG) begin
            d.cfg = wb;
            d.fifo_en = avs_writedata[8];
            d.three_mode_enable = avs_writedata[9];
         end else if (avs_address == fhrb_pkg::OFS_CFG2) begin
            d.cfg2 = wb;
         end
      end
      if (hit_r) begin
         if (avs_address == fhrb_pkg::OFS_PIN_MON_B) begin
            if (layout_select == fhrb_pkg::LAYOUT_REDUCED) begin
               rb = {2'b00, p_now.drive_a_select_pin, q.wd_ff, q.rd_ff,
                     q.wg_ff, 2'b00};
            end else begin
               rb = {2'b11, q.dout[0], q.wd_tog, q.rd_tog,
                     !p_now.write_gate_n, 1'b1,
                     !p_now.motor_a_enable_n};
            end
         end else if (avs_address == fhrb_pkg::OFS_TAPE_MEDIA) begin
            if (q.three_mode_enable) begin
               rb = {q.cfg[5:4], q.cfg2[2*sel+:2], q.cfg[7:6],
                     q.tape_sel};
            end else begin
               rb = {6'b000000, q.tape_sel};
            end
         end else if (avs_address == fhrb_pkg::OFS_RATE_STAT) begin
            rb = {q.fifo_en, 4'h0, q.fifo_cnt};
         end else if (avs_address == fhrb_pkg::OFS_FIFO) begin
            rb = q.fifo[0];
            if (q.fifo_en && q.fifo_cnt != 3'h0) begin
               for (int i = 0; i < DEPTH - 1; i++) begin
                  d.fifo[i] = q.fifo[i+1];
               end
               d.fifo_cnt = q.fifo_cnt - 3'h1;
            end
         end else if (avs_address == fhrb_pkg::OFS_MEDIA_CC) begin
            if (layout_select == fhrb_pkg::LAYOUT_PRIMARY) begin
               rb = {!p_now.disk_change_input, 4'hF, q.rate_eff,
                     (q.rate_eff == fhrb_pkg::RATE_300K ||
                      q.rate_eff == fhrb_pkg::RATE_250K)};
            end else if (layout_select == fhrb_pkg::LAYOUT_REDUCED) begin
               rb = {p_now.disk_change_input, 3'b000, q.dout[3],
                     q.cc_reg[2], q.rate_eff};
            end else begin
               // Floating bits read as ones, like an undriven pulled bus
               rb = {!p_now.disk_change_input,
                     fhrb_pkg::FLOAT_READ[6:0]};
            end
         end else if (avs_address == fhrb_pkg::OFS_STATUS_ZERO) begin
            rb = q.st0;
         end else if (avs_address == fhrb_pkg::OFS_CFG) begin
            rb = q.cfg;
         end else if (avs_address == fhrb_pkg::OFS_CFG2) begin
            rb = q.cfg2;
         end else if (avs_address == fhrb_pkg::OFS_EVENT) begin
            rb = {6'b000000, q.sw_reset, q.rate_reg[6]};
         end
      end
      d.rdata = {24'h00_0000, rb};
      tape2m = tape_rate_2m(q.rate_eff, q.cfg2[7:6]);
      d.pdelay = precomp_ps(q.rate_reg[4:2], q.rate_eff, tape2m,
         layout_select == fhrb_pkg::LAYOUT_REDUCED && q.cc_reg[2]);
      // Software reset clears the FIFO and its enable
      if (q.sw_reset || !q.dout[2]) begin
         d.fifo_cnt = 3'h0;
         d.fifo_en = q.sw_reset ? 1'b0 : d.fifo_en;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Outputs driven from flops (avs_waitrequest low on the ack cycle)
   always_ff @(posedge core_clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
         rate_select <= fhrb_pkg::RATE_500K;
         reduced_write_current <= 1'b1;
         precomp_select <= fhrb_pkg::PRECOMP_DEFAULT;
         precomp_delay <= 16'h0000;
         tape_2m_rate <= 1'b0;
         power_down <= 1'b0;
         controller_reset <= 1'b1;
         motor_enable <= 4'h0;
         drive_select <= 2'h0;
         dma_request_enable <= 1'b0;
      end else begin
         avs_readdata <= d.rdata;
         avs_waitrequest <= !d.ack;
         rate_select <= q.rate_eff;
         reduced_write_current <= q.rate_eff == fhrb_pkg::RATE_500K ||
                                  q.rate_eff == fhrb_pkg::RATE_1M;
         precomp_select <= q.rate_reg[4:2];
         precomp_delay <= q.pdelay;
         tape_2m_rate <= tape_rate_2m(q.rate_eff, q.cfg2[7:6]);
         power_down <= q.rate_reg[6];
         controller_reset <= !q.dout[2] || q.sw_reset;
         motor_enable <= q.dout[7:4];
         drive_select <= q.dout[1:0];
         dma_request_enable <= q.dout[3];
      end
   end
endmodule

// ### testbench/fhrb_drive_model.sv
`timescale 1ns/100ps
module fhrb_drive_model (
   input wire logic core_clk,
   output fhrb_pkg::fhrb_pins_t pins_in
);
   // Gate and motor idle high, no media change
   initial pins_in = fhrb_pkg::fhrb_pins_t'(6'h0C);
   task automatic set_pins(input logic wg_n, input logic moa_n,
                           input logic dsa, input logic dc);
      @(posedge core_clk);
      pins_in.write_gate_n <= wg_n;
      pins_in.motor_a_enable_n <= moa_n;
      pins_in.drive_a_select_pin <= dsa;
      pins_in.disk_change_input <= dc;
   endtask
   // Pulses stay high 4 cycles and low 5 between pulses so the 3-flop sync sees every edge
   task automatic pulse(input logic rd_line, input int n);
      repeat (n) begin
         @(posedge core_clk);
         if (rd_line) pins_in.read_data_in <= 1'b1;
         else pins_in.write_data_out <= 1'b1;
         repeat (4) @(posedge core_clk);
         pins_in.read_data_in <= 1'b0;
         pins_in.write_data_out <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask
endmodule

// ### testbench/fhrb_props.sv
`timescale 1ns/100ps
module fhrb_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] rate_select,
   input wire logic reduced_write_current,
   input wire logic [2:0] precomp_select,
   input wire logic [15:0] precomp_delay,
   input wire logic tape_2m_rate,
   input wire logic power_down,
   input wire logic controller_reset,
   input wire logic [3:0] motor_enable,
   input wire logic [1:0] drive_select,
   input wire logic dma_request_enable
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   logic acc;
   logic [7:0] wd;
   logic [7:0] wd_q;
   assign acc = avs_write && !avs_waitrequest;
   assign wd = avs_writedata[7:0];
   always_ff @(posedge core_clk) wd_q <= wd;
   a_wait_once: assert property ($rose(avs_read || avs_write)
      |=> !avs_waitrequest) else $error("wait state count wrong");
   a_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");
   a_drive_out: assert property (acc && avs_address == 4'h2 |=>
      motor_enable == wd_q[7:4] && dma_request_enable == wd_q[3]
      && drive_select == wd_q[1:0]) else $error("drive output wrong");
   a_reset_held: assert property (acc && avs_address == 4'h2 && !wd[2]
      |=> controller_reset) else $error("controller reset not held");
   a_sw_reset: assert property (acc && avs_address == 4'h4 && wd[7]
      |-> ##[1:3] controller_reset) else $error("no software reset");
   a_rate_fields: assert property (acc && avs_address == 4'h4 |=>
      precomp_select == wd_q[4:2] && power_down == wd_q[6])
      else $error("rate register fields wrong");
   a_last_rate: assert property (acc && (avs_address == 4'h4 ||
      avs_address == 4'h7) |=> rate_select == wd_q[1:0])
      else $error("rate not from last write");
   a_rwc_rate: assert property ($stable(rate_select) |->
      reduced_write_current == (rate_select inside {2'h0, 2'h3}))
      else $error("reduced current wrong for rate");
   a_tape_rate: assert property ($stable(rate_select) && tape_2m_rate
      |-> rate_select == 2'h1) else $error("tape rate with wrong code");
   a_precomp_off: assert property (precomp_select == 3'h7 |=>
      precomp_delay == 16'h0000) else $error("precomp not disabled");
   c_drive_out: cover property (acc && avs_address == 4'h2);
   c_tape_rate: cover property (tape_2m_rate);
   c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule
bind fhrb_top fhrb_checker u_checker (.*);

// ### testbench/test_floppy_host_register_bank.sv
`timescale 1ns/100ps
module test_floppy_host_register_bank;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] layout_select = fhrb_pkg::LAYOUT_PRIMARY;
   fhrb_pkg::fhrb_pins_t pins_in;
   fhrb_pkg::fhrb_st0_t status_zero_in = '0;
   logic status_zero_load = 1'b0;
   logic [1:0] rate_select;
   logic reduced_write_current;
   logic [2:0] precomp_select;
   logic [15:0] precomp_delay;
   logic tape_2m_rate;
   logic power_down;
   logic controller_reset;
   logic [3:0] motor_enable;
   logic [1:0] drive_select;
   logic dma_request_enable;
   logic [31:0] q;
   logic [7:0] dr_v [3] = '{8'h44, 8'h08, 8'h1C};
   logic [15:0] dl_v [3] = '{16'h1047, 16'h208E, 16'h0000};
   int errors = 0;
   int checked = 0;
   fhrb_top DUT (.*);
   fhrb_drive_model model (.*);
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 40) begin
         errors++;
         close_out();
      end
   endtask
   // Upper bits are always compared, low byte under mask
   task automatic rd(input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(q & {24'hFF_FFFF, m}, {24'h00_0000, e});
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      repeat (2) @(posedge core_clk);
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      chk({rate_select, reduced_write_current, controller_reset}, 4'h3);
      rst <= 1'b0;
      rd(4'h6, 8'hFF, 8'h00);
      for (int r = 0; r < 4; r++) begin
         wr(4'h4, r);
         chk(rate_select, r[1:0]);
         chk(reduced_write_current, r == 0 || r == 3);
         chk(precomp_delay, r == 3 ? 16'h1047 : 16'h30D4);
         rd(4'h7, 8'hFF, {5'h1F, r[1:0], r == 1 || r == 2});
      end
      for (int i = 0; i < 3; i++) begin
         wr(4'h4, dr_v[i]);
         chk({power_down, precomp_select}, {dr_v[i][6], dr_v[i][4:2]});
         chk(precomp_delay, dl_v[i]);
      end
      $display("test rates done");
      wr(4'h7, 8'h02);
      chk(rate_select, 2'h2);
      wr(4'h4, 8'h01);
      chk(rate_select, 2'h1);
      wr(4'hA, 8'hA4);
      chk({tape_2m_rate, precomp_delay}, 17'h1_0820);
      wr(4'h4, 8'h00);
      chk(tape_2m_rate, 1'b0);
      $display("test last write and tape rate done");
      model.set_pins(1'b0, 1'b1, 1'b1, 1'b0);
      wr(4'h2, 8'h1D);
      chk({motor_enable, dma_request_enable, controller_reset,
           drive_select}, 8'h19);
      model.pulse(1'b0, 1);
      model.pulse(1'b1, 3);
      rd(4'h1, 8'h3D, 8'h3C);
      for (int t = 0; t < 4; t++) begin
         wr(4'h3, t);
         rd(4'h3, 8'h03, t[1:0]);
      end
      wr(4'h9, 32'h0000_02B0);
      rd(4'h3, 8'hFF, 8'hDB);
      wr(4'h2, 8'h10);
      chk(controller_reset, 1'b1);
      wr(4'h4, 8'h80);
      $display("test drive and tape done");
      wr(4'h2, 8'h14);
      wr(4'h9, 32'h0000_0100);
      wr(4'h5, 8'h5A);
      wr(4'h5, 8'hA5);
      rd(4'h4, 8'h87, 8'h82);
      rd(4'h5, 8'hFF, 8'h5A);
      rd(4'h5, 8'hFF, 8'hA5);
      $display("test fifo done");
      for (int i = 0; i < 3; i++) begin
         status_zero_in <= fhrb_pkg::fhrb_st0_t'({i[1:0], i[0], 5'h0A});
         status_zero_load <= 1'b1;
         @(posedge core_clk);
         status_zero_load <= 1'b0;
         rd(4'h8, 8'hFF, {i[1:0], i[0], 5'h0A});
      end
      $display("test status zero done");
      layout_select <= fhrb_pkg::LAYOUT_REDUCED;
      model.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
      model.pulse(1'b0, 1);
      rd(4'h1, 8'h3C, 8'h24);
      wr(4'h7, 8'h06);
      chk(precomp_delay, 16'h0000);
      rd(4'h7, 8'hFF, 8'h86);
      layout_select <= fhrb_pkg::LAYOUT_AT;
      rd(4'h7, 8'hFF, 8'h7F);
      $display("test layouts done");
      close_out();
   end
endmodule
